// ---- core/gdpc_pkg.sv ----
package gdpc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned          NUM_PINS        = 13;
    localparam int unsigned          PU_LO           = 9;
    localparam int unsigned          PU_HI           = 12;
    localparam logic [7:0]           IDX_DBC_EN      = 8'h80;
    localparam logic [7:0]           IDX_PULLUP_EN   = 8'h81;
    localparam logic [7:0]           IDX_DBC_TIME    = 8'h82;
    localparam logic [7:0]           IDX_PIN_LEVEL   = 8'h83;
    localparam int unsigned          ADR_W           = 12;
    localparam logic [ADR_W-1:0]     ADR_DBC_EN      = ADR_W'({IDX_DBC_EN, 2'b00});
    localparam logic [ADR_W-1:0]     ADR_PULLUP_EN   = ADR_W'({IDX_PULLUP_EN, 2'b00});
    localparam logic [ADR_W-1:0]     ADR_DBC_TIME    = ADR_W'({IDX_DBC_TIME, 2'b00});
    localparam logic [ADR_W-1:0]     ADR_PIN_LEVEL   = ADR_W'({IDX_PIN_LEVEL, 2'b00});

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [12:0]          RST_DBC_EN      = 13'h1FFF;
    localparam logic [3:0]           RST_PULLUP_EN   = 4'h0;
    localparam logic [1:0]           RST_DBC_TIME    = 2'h0;

    // ****************************************************************
    // debounce times
    // ****************************************************************
    localparam int unsigned          CLK_MHZ         = 125;
    localparam int unsigned          DBC_TIME0_US    = 62;
    localparam int unsigned          DBC_TIME1_US    = 125;
    localparam int unsigned          DBC_TIME2_US    = 250;
    localparam int unsigned          DBC_TIME3_US    = 500;
    localparam int unsigned          DBC_CYC0        = DBC_TIME0_US * CLK_MHZ;
    localparam int unsigned          DBC_CYC1        = DBC_TIME1_US * CLK_MHZ;
    localparam int unsigned          DBC_CYC2        = DBC_TIME2_US * CLK_MHZ;
    localparam int unsigned          DBC_CYC3        = DBC_TIME3_US * CLK_MHZ;
    localparam int unsigned          CNT_W           = 16;

    // ****************************************************************
    // filter states
    // ****************************************************************
    typedef enum logic [1:0] {
        GDPC_ST_STABLE = 2'h0,
        GDPC_ST_WAIT   = 2'h1
    } gdpc_state_e;

endpackage

// ---- core/gdpc_debounce.sv ----
`timescale 1ns/1ps
module gdpc_debounce (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       clk_en_i,
    // control
    input  wire logic                       dbc_en_i,
    input  wire logic [gdpc_pkg::CNT_W-1:0] limit_i,
    // pin
    input  wire logic                       pin_i,
    output logic                            level_o
);

    // ****************************************************************
    // synchroniser
    // ****************************************************************
    // first stage only feeds the second
    logic [2:0]                  sync_q;
    logic                        level_q;
    logic                        level_d;
    logic [gdpc_pkg::CNT_W-1:0]  cnt_q;
    logic [gdpc_pkg::CNT_W-1:0]  cnt_d;
    gdpc_pkg::gdpc_state_e       state_q;
    gdpc_pkg::gdpc_state_e       state_d;
    wire                         agree  = (sync_q[1] == sync_q[2]);
    wire                         cand   = sync_q[2];
    wire                         change = agree && (cand != level_q);
    wire                         done   = (cnt_q >= limit_i);

    // ****************************************************************
    // filter
    // ****************************************************************
    always_comb begin
        level_d = level_q;
        cnt_d   = cnt_q;
        state_d = state_q;
        if (!dbc_en_i) begin
            if (change) begin
                level_d = cand;
            end
            state_d = gdpc_pkg::GDPC_ST_STABLE;
            cnt_d   = '0;
        end else begin
            case (state_q)
                gdpc_pkg::GDPC_ST_STABLE: begin
                    if (change) begin
                        state_d = gdpc_pkg::GDPC_ST_WAIT;
                        cnt_d   = 16'h0001;
                    end
                end
                gdpc_pkg::GDPC_ST_WAIT: begin
                    // any bounce restarts the wait
                    if (!change) begin
                        state_d = gdpc_pkg::GDPC_ST_STABLE;
                        cnt_d   = '0;
                    end else if (done) begin
                        level_d = cand;
                        state_d = gdpc_pkg::GDPC_ST_STABLE;
                        cnt_d   = '0;
                    end else begin
                        cnt_d   = cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_d = gdpc_pkg::GDPC_ST_STABLE;
                    cnt_d   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            cnt_q   <= '0;
            state_q <= gdpc_pkg::GDPC_ST_STABLE;
        end else if (clk_en_i) begin
            sync_q  <= {sync_q[1:0], pin_i};
            level_q <= level_d;
            cnt_q   <= cnt_d;
            state_q <= state_d;
        end
    end

    assign level_o = level_q;

endmodule

// ---- core/gdpc_top.sv ----
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
// Operation
// - each of pins 12..0 has a debounce enable; clear passes the synchronised input with no debounce wait.
// - all debounced pins share one two-bit time select field.
// - power-management reset sets every debounce enable to one.
// - pull-up enable for each of pins 12..9, effective only while that pin is an input.
// - power-management reset clears pull-up enables to a fixed zero.
module gdpc_top #(
    parameter int unsigned DBC_CYC0 = gdpc_pkg::DBC_CYC0,
    parameter int unsigned DBC_CYC1 = gdpc_pkg::DBC_CYC1,
    parameter int unsigned DBC_CYC2 = gdpc_pkg::DBC_CYC2,
    parameter int unsigned DBC_CYC3 = gdpc_pkg::DBC_CYC3
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        clk_en_i,
    input  wire logic                        pm_reset_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [gdpc_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // pins
    input  wire logic [12:0]                 pin_i,
    input  wire logic [12:0]                 pin_is_input_i,
    output logic [12:0]                      pin_level_o,
    output logic [12:9]                      pin_pullup_o
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic hit(input logic [gdpc_pkg::ADR_W-1:0] adr,
                                 input logic [gdpc_pkg::ADR_W-1:0] reg_adr);
        hit = (adr[gdpc_pkg::ADR_W-1:2] == reg_adr[gdpc_pkg::ADR_W-1:2]);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [12:0]  dbc_en_q;
    logic [3:0]   pullup_en_q;
    logic [1:0]   dbc_time_q;
    logic         ack_q;
    logic [31:0]  rdat_q;
    logic [12:0]  level_w;

    wire          req        = wb_cyc_i && wb_stb_i;
    wire          wr_commit  = req && wb_we_i && ack_q;
    wire          hit_dbc    = hit(wb_adr_i, gdpc_pkg::ADR_DBC_EN);
    wire          hit_pu     = hit(wb_adr_i, gdpc_pkg::ADR_PULLUP_EN);
    wire          hit_time   = hit(wb_adr_i, gdpc_pkg::ADR_DBC_TIME);
    wire          hit_level  = hit(wb_adr_i, gdpc_pkg::ADR_PIN_LEVEL);
    wire [15:0]   dbc_wr     = merge16({3'h0, dbc_en_q}, wb_dat_i, wb_sel_i);
    wire [15:0]   pu_wr      = merge16({3'h0, pullup_en_q, 9'h000}, wb_dat_i, wb_sel_i);
    wire [15:0]   time_wr    = merge16({14'h0000, dbc_time_q}, wb_dat_i, wb_sel_i);

    // unmapped reads answer zero
    wire [31:0]   rdat_w     = hit_dbc   ? {19'h00000, dbc_en_q} :
                               hit_pu    ? {19'h00000, pullup_en_q, 9'h000} :
                               hit_time  ? {30'h00000000, dbc_time_q} :
                               hit_level ? {19'h00000, level_w} : 32'h00000000;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dbc_en_q    <= gdpc_pkg::RST_DBC_EN;
            pullup_en_q <= gdpc_pkg::RST_PULLUP_EN;
            dbc_time_q  <= gdpc_pkg::RST_DBC_TIME;
        end else if (clk_en_i) begin
            if (pm_reset_i) begin
                dbc_en_q    <= gdpc_pkg::RST_DBC_EN;
                pullup_en_q <= gdpc_pkg::RST_PULLUP_EN;
                dbc_time_q  <= gdpc_pkg::RST_DBC_TIME;
            end else if (wr_commit) begin
                if (hit_dbc) begin
                    dbc_en_q <= dbc_wr[12:0];
                end
                if (hit_pu) begin
                    pullup_en_q <= pu_wr[12:9];
                end
                if (hit_time) begin
                    dbc_time_q <= time_wr[1:0];
                end
            end
        end
    end

    // ****************************************************************
    // bus answer
    // ****************************************************************
    // one wait state keeps read data registered
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else if (clk_en_i) begin
            ack_q  <= req && !ack_q;
            rdat_q <= (req && !ack_q && !wb_we_i) ? rdat_w : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ****************************************************************
    // debounce per pin
    // ****************************************************************
    // one shared limit; time select applies to all pins alike
    wire [gdpc_pkg::CNT_W-1:0] limit_w =
        (dbc_time_q == 2'h0) ? gdpc_pkg::CNT_W'(DBC_CYC0) :
        (dbc_time_q == 2'h1) ? gdpc_pkg::CNT_W'(DBC_CYC1) :
        (dbc_time_q == 2'h2) ? gdpc_pkg::CNT_W'(DBC_CYC2) :
                               gdpc_pkg::CNT_W'(DBC_CYC3);

    genvar g;
    generate
        for (g = 0; g < gdpc_pkg::NUM_PINS; g = g + 1) begin : g_pin
            gdpc_debounce u_dbc (
                .clk_sys_i (clk_sys_i),
                .reset_n_i (reset_n_i),
                .clk_en_i  (clk_en_i),
                .dbc_en_i  (dbc_en_q[g]),
                .limit_i   (limit_w),
                .pin_i     (pin_i[g]),
                .level_o   (level_w[g])
            );
        end
    endgenerate

    assign pin_level_o = level_w;

    // ****************************************************************
    // pull-up
    // ****************************************************************
    // pull-down lives elsewhere; mutual exclusion is up to software
    assign pin_pullup_o = pullup_en_q & pin_is_input_i[12:9];

endmodule

// ---- verification/gdpc_pin_model.sv ----
`timescale 1ns/1ps
module gdpc_pin_model (
    // clock
    input  wire logic        clk_i,
    // bench drive and device pull-up
    input  wire logic [12:0] drv_en_i,
    input  wire logic [12:0] drv_val_i,
    input  wire logic [12:9] pullup_i,
    // pins
    output logic      [12:0] pin_o
);
    // ****************
    // pin levels
    // ****************
    logic [12:0] flip_q = 13'h0;
    // a floating line keeps changing so a stale level never passes as real
    always @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end
    assign pin_o = (drv_en_i & drv_val_i) | (~drv_en_i & ({pullup_i, 9'h0} | flip_q));
endmodule

// ---- verification/gdpc_checker.sv ----
`timescale 1ns/1ps
module gdpc_checker (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        clk_en_i,
    input wire logic        pm_reset_i,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic [12:0] pin_i,
    input wire logic [12:0] pin_is_input_i,
    input wire logic [12:0] pin_level_o,
    input wire logic [12:9] pin_pullup_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // ****************
    // bus answer
    // ****************
    ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i |=> wb_ack_o)
        else $error("request not acked in next cycle");
    ack_once_a: assert property (wb_ack_o && clk_en_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    freeze_a: assert property (!clk_en_i |=> $stable(pin_level_o) && $stable(wb_ack_o))
        else $error("state moved with clock enable low");
    // ****************
    // pins
    // ****************
    pullup_dir_a: assert property ((pin_pullup_o & ~pin_is_input_i[12:9]) == 4'h0)
        else $error("pull-up on a pin that is not an input");
    pm_pullup_a: assert property (pm_reset_i && clk_en_i |=> pin_pullup_o == 4'h0)
        else $error("pull-up survived power reset");
    level_cause_a: assert property ($rose(pin_level_o[0]) |->
        $past(pin_i[0], 3) || $past(pin_i[0], 4) || $past(pin_i[0], 5))
        else $error("level rose without a high pin");
endmodule
bind gdpc_top gdpc_checker u_chk (.clk_sys_i, .reset_n_i, .clk_en_i, .pm_reset_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_is_input_i, .pin_level_o, .pin_pullup_o);

// ---- verification/test_gdpc_top.sv ----
`timescale 1ns/1ps
module test_gdpc_top;
    logic        clk, rst_n, clk_en, pm_rst, cyc, stb, we, ack;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [12:0] is_in, drv_en, drv_val, pins, level;
    logic [12:9] pull;
    int          error_cnt = 0;
    int          checked = 0;
    // short counts keep the run brief
    gdpc_top #(.DBC_CYC0(8), .DBC_CYC1(16), .DBC_CYC2(32), .DBC_CYC3(64)) dut (
        .clk_sys_i(clk), .reset_n_i(rst_n), .clk_en_i(clk_en), .pm_reset_i(pm_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pins),
        .pin_is_input_i(is_in), .pin_level_o(level), .pin_pullup_o(pull));
    gdpc_pin_model u_pins (.clk_i(clk), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .pullup_i(pull), .pin_o(pins));
    // ****************
    // helpers
    // ****************
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'h3, d};
        // only the watchdog ends a wait for ack
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        bus(1'h0, 12'h200, 32'h0);
        chk(q, 32'h1FFF);
        bus(1'h0, 12'h204, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, 12'h3F0, 32'h0);
        chk(q, 32'h0);
        bus(1'h1, 12'h204, 32'hFFFFFFFF);
        bus(1'h0, 12'h204, 32'h0);
        chk(q, 32'h1E00);
        $display("t_regs done");
    endtask
    task automatic t_pins();
        bus(1'h1, 12'h200, 32'h0);
        drv_val <= 13'h1555;
        repeat (8) @(posedge clk);
        chk(level, 13'h1555);
        bus(1'h0, 12'h20C, 32'h0);
        chk(q, 32'h1555);
        drv_val <= 13'h0;
        drv_en <= 13'h1DFF;
        repeat (8) @(posedge clk);
        chk(pull, 4'hF);
        chk(level, 13'h0200);
        is_in <= 13'h0BFF;
        repeat (2) @(posedge clk);
        chk(pull, 4'h5);
        {drv_en, is_in} <= {13'h1FFF, 13'h1FFF};
        $display("t_pins done");
    endtask
    task automatic t_dbc();
        int lim;
        bus(1'h1, 12'h200, 32'h1);
        for (int s = 0; s < 4; s++) begin
            lim = 8 << s;
            bus(1'h1, 12'h208, 32'(s));
            drv_val <= 13'h1;
            repeat (lim / 2) @(posedge clk);
            drv_val <= 13'h0;
            repeat (lim + 8) @(posedge clk);
            chk(level[0], 1'h0);
            drv_val <= 13'h3;
            repeat (6) @(posedge clk);
            chk(level[1:0], 2'h2);
            // level may move only lim + 4 edges after the pin
            repeat (lim - 4) @(posedge clk);
            chk(level[0], 1'h0);
            repeat (8) @(posedge clk);
            chk(level[1:0], 2'h3);
            drv_val <= 13'h0;
            repeat (lim + 8) @(posedge clk);
        end
        $display("t_dbc done");
    endtask
    task automatic t_pm();
        bus(1'h1, 12'h204, 32'h1E00); // only pull-ups, never a pull-down
        clk_en <= 1'h0;
        drv_val <= 13'h2;
        repeat (6) @(posedge clk);
        // frozen: the raw pin change must not get through
        chk(level, 13'h0);
        {clk_en, pm_rst} <= 2'h3;
        @(posedge clk);
        pm_rst <= 1'h0;
        bus(1'h0, 12'h200, 32'h0);
        chk(q, 32'h1FFF);
        bus(1'h0, 12'h204, 32'h0);
        chk(q, 32'h0);
        $display("t_pm done");
    endtask
    initial begin
        {rst_n, clk_en, pm_rst, cyc, stb, we, adr, sel, wdat} = {6'h10, 12'h0, 4'h3, 32'h0};
        {is_in, drv_en, drv_val} = {13'h1FFF, 13'h1FFF, 13'h0};
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_pins();
        t_dbc();
        t_pm();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
